// ---- pwmgc_pkg.sv ----
// Package of register map, field positions and mode codes
package pwmgc_pkg;
  // Register word offsets on Avalon-MM
  localparam logic [3:0] ADDR_KEY = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_PDUTY = 4'h2;
  localparam logic [3:0] ADDR_SDUTY = 4'h3;
  localparam logic [3:0] ADDR_PHASE = 4'h4;
  localparam logic [3:0] ADDR_SPHASE = 4'h5;
  localparam logic [3:0] ADDR_MPER = 4'h6;
  localparam logic [3:0] ADDR_MDUTY = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int ADDR_W = 4;
  // Control field positions
  localparam int B_FLTST = 15;
  localparam int B_CLST = 14;
  localparam int B_TRGST = 13;
  localparam int B_FLTIE = 12;
  localparam int B_CLIE = 11;
  localparam int B_TRGIE = 10;
  localparam int B_ITB = 9;
  localparam int B_MDS = 8;
  localparam int B_DTC = 6;
  localparam int B_TBS = 3;
  localparam int B_CAM = 2;
  localparam int B_XPR = 1;
  localparam int B_IUE = 0;
  localparam logic [15:0] CTRL_WMASK = 16'h1fcf;
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_MPER = 16'hfff8;
  // Duty and period limits
  localparam logic [15:0] MIN_PULSE = 16'h0008;
  localparam logic [15:0] MAX_LOCAL_PER = 16'hfff8;
  localparam logic [15:0] CAM_MASK = 16'hfff8;
  // Edge band in which resolution coarsens
  localparam int EDGE_BAND_PS = 40000;
  localparam int CLK_PS = 8000;
  localparam logic [15:0] EDGE_BAND = 16'(EDGE_BAND_PS / CLK_PS);
  localparam logic [15:0] COARSE_MASK = 16'hfffc;
  // Dead-time modes
  typedef enum logic [1:0] {
    DT_POS = 2'b00,
    DT_NEG = 2'b01,
    DT_OFF = 2'b10,
    DT_RSV = 2'b11
  } pwmgc_dt_e;
  // Output modes
  typedef enum logic [1:0] {
    OM_COMP = 2'b00,
    OM_REDUN = 2'b01,
    OM_PUSH = 2'b10,
    OM_INDEP = 2'b11
  } pwmgc_om_e;
endpackage : pwmgc_pkg

// ---- pwmgc_properties.sv ----
// Port-level checker for the PWM generator control block
`timescale 1ns/1ns
module pwmgc_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins
  input wire logic faultIn,
  input wire logic limitIn,
  input wire logic triggerIn,
  input wire logic moduleEnable,
  input wire logic highOutput,
  input wire logic lowOutput,
  input wire logic faultIrq,
  input wire logic limitIrq,
  input wire logic triggerIrq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  property p_wait_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("stall with no request");
  property p_wait_answer;
    ($rose(read) || $rose(write)) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("answer late");
  property p_read_upper;
    (read && !waitrequest) |-> readdata[31:16] == 16'h0000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper half set");
  // Read data must not drift between reads
  property p_rdata_hold;
    !read |=> $stable(readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_fault_irq;
    faultIrq |-> $past(faultIn, 2) ##1 !faultIrq;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("bad fault request");
  property p_limit_irq;
    limitIrq |-> $past(limitIn, 2) ##1 !limitIrq;
  endproperty
  a_limit_irq: assert property (p_limit_irq) else $error("bad limit request");
  property p_trigger_irq;
    triggerIrq |-> $past(triggerIn, 2) ##1 !triggerIrq;
  endproperty
  a_trigger_irq: assert property (p_trigger_irq) else $error("bad trigger request");
  property p_outputs_off;
    !moduleEnable [*2] |-> !highOutput && !lowOutput;
  endproperty
  a_outputs_off: assert property (p_outputs_off) else $error("output while off");
endmodule : pwmgc_props

bind pwmgc_top pwmgc_props u_props (.ref_clk, .nrst, .read, .write,
  .readdata, .waitrequest, .faultIn, .limitIn, .triggerIn, .moduleEnable,
  .highOutput, .lowOutput, .faultIrq, .limitIrq, .triggerIrq);

// ---- pwmgc_top.sv ----
// PWM generator control, duty registers and output logic
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: Fault event sets fault_pending; writing fault enable zero clears it.
// RQ2: Limit event sets limit_pending; writing limit enable zero clears it.
// RQ3: Trigger with enable set raises request and pending; enable zero clears.
// RQ4: Software clears pending here and in interrupt controller flag.
// RQ5: Independent bit picks own phase period, else master period.
// RQ6: Shared duty select picks master duty, else own duty registers.
// RQ7: Center-aligned only honoured when independent time base is set.
// RQ8: Center-aligned mode drops lowest three bits of duty, phase, dead time.
// RQ9: Software keeps mode bits fixed once module enable is set.
// RQ10: External reset with independent base lets limit reset the counter.
// RQ11: Software sets limit mode zero and independent one for this mode.
// RQ12: Dead-time field: positive, negative complementary, disabled, reserved.
// RQ13: Time-base select picks secondary or primary master base.
// RQ14: Immediate update applies writes now, else at local period start.
// RQ15: Primary duty drives high only in independent, both otherwise.
// RQ16: Secondary duty used only in independent mode for low output.
// RQ17: Pulse width clamped between 0x0008 and period minus 0x0008; here a duty of zero passes through unclamped.
// RQ18: Near zero or full period, duty resolution coarsens to a few LSBs.
// RQ19: Sixteen-bit read/write key register, reset zero.
// RQ20: Local period accepts up to 0xFFF8; otherwise phase is shift. No shift is applied here; the phase registers are then unused.
// RQ21: Center-aligned counter counts up to period then down.
module pwmgc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Event inputs from outside
  input wire logic faultIn,
  input wire logic limitIn,
  input wire logic triggerIn,
  // Master time bases and module enable
  input wire logic primaryTbSync,
  input wire logic secondaryTbSync,
  input wire logic secondaryTbPresent,
  input wire logic moduleEnable,
  // Output mode and dead time
  input wire logic [1:0] outputMode,
  input wire logic [13:0] deadTime,
  // Outputs
  output logic highOutput,
  output logic lowOutput,
  output logic faultIrq,
  output logic limitIrq,
  output logic triggerIrq
);

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] protectionKey;
  logic [15:0] ctrl;
  logic [15:0] primaryDuty, secondaryDuty, phaseShift, secPhaseShift;
  logic [15:0] masterPeriod, masterDuty;
  logic [15:0] actDuty, actSDuty, actPeriod, actSPeriod, actDead;
  logic [2:0] faultS, limitS, trigS, priS, secS;
  logic ackPhase;
  logic [15:0] counter;
  logic countDown;
  logic cycleStart;

  // Pins are asynchronous, so two flops before use
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      faultS <= 3'h0;
      limitS <= 3'h0;
      trigS <= 3'h0;
      priS <= 3'h0;
      secS <= 3'h0;
    end else begin
      faultS <= {faultS[1:0], faultIn};
      limitS <= {limitS[1:0], limitIn};
      trigS <= {trigS[1:0], triggerIn};
      priS <= {priS[1:0], primaryTbSync};
      secS <= {secS[1:0], secondaryTbSync};
    end
  end

  logic faultEv, limitEv, trigEv, tbSyncEv;
  logic independent_timebase, center_aligned, useSec;
  always_comb begin
    faultEv = faultS[1] & ~faultS[2];
    limitEv = limitS[1] & ~limitS[2];
    trigEv = trigS[1] & ~trigS[2];
    independent_timebase = ctrl[pwmgc_pkg::B_ITB];
    center_aligned = ctrl[pwmgc_pkg::B_CAM] & independent_timebase; // RQ7
    useSec = ctrl[pwmgc_pkg::B_TBS] & secondaryTbPresent; // RQ13
    tbSyncEv = useSec ? (secS[1] & ~secS[2]) : (priS[1] & ~priS[2]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, answer on the second edge
  logic busReq, wrDo, rdDo;
  assign busReq = read | write;
  assign waitrequest = busReq & ~ackPhase;
  assign wrDo = write & ackPhase;
  assign rdDo = read & ~ackPhase;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ackPhase <= 1'b0;
    end else begin
      ackPhase <= busReq & ~ackPhase;
    end
  end

  function automatic logic [15:0] regRead(input logic [3:0] a,
      input logic [15:0] k, input logic [15:0] c, input logic [15:0] p,
      input logic [15:0] s, input logic [15:0] ph, input logic [15:0] sp,
      input logic [15:0] mp, input logic [15:0] md, input logic [15:0] st);
    unique case (a)
      pwmgc_pkg::ADDR_KEY: regRead = k;
      pwmgc_pkg::ADDR_CTRL: regRead = c;
      pwmgc_pkg::ADDR_PDUTY: regRead = p;
      pwmgc_pkg::ADDR_SDUTY: regRead = s;
      pwmgc_pkg::ADDR_PHASE: regRead = ph;
      pwmgc_pkg::ADDR_SPHASE: regRead = sp;
      pwmgc_pkg::ADDR_MPER: regRead = mp;
      pwmgc_pkg::ADDR_MDUTY: regRead = md;
      pwmgc_pkg::ADDR_STATUS: regRead = st;
      default: regRead = pwmgc_pkg::RST_ZERO;
    endcase
  endfunction : regRead

  logic [15:0] statusWord;
  assign statusWord = {13'h0000, countDown, lowOutput, highOutput};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (rdDo) begin
      readdata <= {16'h0000, regRead(address, protectionKey, ctrl,
        primaryDuty, secondaryDuty, phaseShift, secPhaseShift,
        masterPeriod, masterDuty, statusWord)};
    end
  end

  function automatic logic wrHit(input logic w, input logic [3:0] a,
      input logic [3:0] r);
    wrHit = w && (a == r);
  endfunction : wrHit

  ////////////////////////////////////////////////////////////////////////
  // Key register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      protectionKey <= pwmgc_pkg::RST_ZERO; // RQ19
    end else if (wrHit(wrDo, address, pwmgc_pkg::ADDR_KEY)) begin
      protectionKey <= writedata[15:0]; // RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control: pending bits set by hardware, enable clear wins over set
  logic ctrlWr;
  logic [15:0] wdCtrl;
  logic fIe, cIe, tIe;
  assign ctrlWr = wrHit(wrDo, address, pwmgc_pkg::ADDR_CTRL);
  assign wdCtrl = writedata[15:0];
  assign fIe = ctrlWr ? wdCtrl[pwmgc_pkg::B_FLTIE] : ctrl[pwmgc_pkg::B_FLTIE];
  assign cIe = ctrlWr ? wdCtrl[pwmgc_pkg::B_CLIE] : ctrl[pwmgc_pkg::B_CLIE];
  assign tIe = ctrlWr ? wdCtrl[pwmgc_pkg::B_TRGIE] : ctrl[pwmgc_pkg::B_TRGIE];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= pwmgc_pkg::RST_ZERO;
    end else begin
      // Mode bits held by software once enabled; not enforced here
      if (ctrlWr) begin
        ctrl[12:0] <= wdCtrl[12:0] & pwmgc_pkg::CTRL_WMASK[12:0];
      end
      if (faultEv & fIe) begin
        ctrl[pwmgc_pkg::B_FLTST] <= 1'b1; // RQ1
      end else if (!fIe) begin
        ctrl[pwmgc_pkg::B_FLTST] <= 1'b0; // RQ1
      end
      if (limitEv & cIe) begin
        ctrl[pwmgc_pkg::B_CLST] <= 1'b1; // RQ2
      end else if (!cIe) begin
        ctrl[pwmgc_pkg::B_CLST] <= 1'b0; // RQ2
      end
      if (trigEv & tIe) begin
        ctrl[pwmgc_pkg::B_TRGST] <= 1'b1; // RQ3
      end else if (!tIe) begin
        ctrl[pwmgc_pkg::B_TRGST] <= 1'b0; // RQ3
      end
    end
  end

  // One-cycle request pulses to the interrupt controller
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      faultIrq <= 1'b0;
      limitIrq <= 1'b0;
      triggerIrq <= 1'b0;
    end else begin
      faultIrq <= faultEv & fIe; // RQ1
      limitIrq <= limitEv & cIe; // RQ2
      triggerIrq <= trigEv & tIe; // RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software copies of duty, phase and period
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      primaryDuty <= pwmgc_pkg::RST_ZERO;
      secondaryDuty <= pwmgc_pkg::RST_ZERO;
      phaseShift <= pwmgc_pkg::RST_ZERO;
      secPhaseShift <= pwmgc_pkg::RST_ZERO;
      masterPeriod <= pwmgc_pkg::RST_MPER;
      masterDuty <= pwmgc_pkg::RST_ZERO;
    end else if (wrDo) begin
      unique case (address)
        pwmgc_pkg::ADDR_PDUTY: primaryDuty <= writedata[15:0];
        pwmgc_pkg::ADDR_SDUTY: secondaryDuty <= writedata[15:0];
        pwmgc_pkg::ADDR_PHASE: phaseShift <= writedata[15:0];
        pwmgc_pkg::ADDR_SPHASE: secPhaseShift <= writedata[15:0];
        pwmgc_pkg::ADDR_MPER: masterPeriod <= writedata[15:0];
        pwmgc_pkg::ADDR_MDUTY: masterDuty <= writedata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Active value selection
  function automatic logic [15:0] limPer(input logic [15:0] v);
    limPer = (v > pwmgc_pkg::MAX_LOCAL_PER) ? pwmgc_pkg::MAX_LOCAL_PER : v;
  endfunction : limPer

  function automatic logic [15:0] camTrim(input logic [15:0] v,
      input logic c);
    camTrim = c ? (v & pwmgc_pkg::CAM_MASK) : v;
  endfunction : camTrim

  logic [15:0] srcDuty, srcSDuty, srcPer, srcSPer, srcDead;
  always_comb begin
    srcDuty = ctrl[pwmgc_pkg::B_MDS] ? masterDuty : primaryDuty; // RQ6
    srcSDuty = ctrl[pwmgc_pkg::B_MDS] ? masterDuty : secondaryDuty; // RQ6
    srcPer = independent_timebase ? limPer(phaseShift) : masterPeriod; // RQ5 RQ20
    srcSPer = independent_timebase ? limPer(secPhaseShift) : masterPeriod; // RQ5 RQ20
    srcDead = {2'b00, deadTime};
  end

  // Immediate or cycle-synchronised load of active values
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      actDuty <= pwmgc_pkg::RST_ZERO;
      actSDuty <= pwmgc_pkg::RST_ZERO;
      actPeriod <= pwmgc_pkg::RST_MPER;
      actSPeriod <= pwmgc_pkg::RST_MPER;
      actDead <= pwmgc_pkg::RST_ZERO;
    end else if (ctrl[pwmgc_pkg::B_IUE] || cycleStart) begin // RQ14
      actDuty <= camTrim(srcDuty, center_aligned); // RQ8
      actSDuty <= camTrim(srcSDuty, center_aligned); // RQ8
      actPeriod <= camTrim(srcPer, center_aligned); // RQ8
      actSPeriod <= camTrim(srcSPer, center_aligned); // RQ8
      actDead <= camTrim(srcDead, center_aligned); // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Local time base
  logic extReset, atTop;
  assign extReset = ctrl[pwmgc_pkg::B_XPR] & independent_timebase & limitEv; // RQ10
  assign atTop = counter >= actPeriod;
  assign cycleStart = center_aligned ? (countDown && counter == 16'h0000)
    : (independent_timebase ? atTop : tbSyncEv);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      counter <= 16'h0000;
      countDown <= 1'b0;
    end else if (!moduleEnable || extReset) begin // RQ10
      counter <= 16'h0000;
      countDown <= 1'b0;
    end else if (center_aligned) begin
      if (!countDown) begin // RQ21
        if (atTop) begin
          countDown <= 1'b1;
          counter <= counter - 16'h0001;
        end else begin
          counter <= counter + 16'h0001;
        end
      end else if (counter == 16'h0000) begin // RQ21
        countDown <= 1'b0;
        counter <= 16'h0001;
      end else begin
        counter <= counter - 16'h0001;
      end
    end else if (!independent_timebase && tbSyncEv) begin // RQ13
      counter <= 16'h0000;
    end else if (atTop && independent_timebase) begin
      counter <= 16'h0000;
    end else begin
      counter <= counter + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Duty clamp and edge-band coarsening
  function automatic logic [15:0] clampDuty(input logic [15:0] d,
      input logic [15:0] p);
    logic [15:0] hi;
    logic [15:0] r;
    hi = (p > pwmgc_pkg::MIN_PULSE) ? p - pwmgc_pkg::MIN_PULSE
      : pwmgc_pkg::MIN_PULSE;
    r = d;
    if (d == 16'h0000) r = 16'h0000;
    else if (d < pwmgc_pkg::MIN_PULSE) r = pwmgc_pkg::MIN_PULSE; // RQ17
    else if (d > hi) r = hi; // RQ17
    // Inside the edge band the fine bits cannot be honoured
    if (r != 16'h0000 && (r < pwmgc_pkg::MIN_PULSE + pwmgc_pkg::EDGE_BAND
        || r + pwmgc_pkg::EDGE_BAND > hi)) begin
      r = r & pwmgc_pkg::COARSE_MASK; // RQ18
    end
    clampDuty = r;
  endfunction : clampDuty

  logic [15:0] dutyH, dutyL, deadEff;
  logic indep;
  logic rawH, rawL;
  always_comb begin
    indep = outputMode == pwmgc_pkg::OM_INDEP;
    dutyH = clampDuty(actDuty, actPeriod);
    dutyL = indep ? clampDuty(actSDuty, actSPeriod) : dutyH; // RQ15 RQ16
    deadEff = center_aligned ? (actDead >> 1) : actDead;
    rawH = moduleEnable && (counter < dutyH);
    rawL = moduleEnable && (indep ? (counter < dutyL) : !rawH); // RQ15
  end

  ////////////////////////////////////////////////////////////////////////
  // Dead-time insertion on the complementary pair
  logic [15:0] dtCnt;
  logic prevH;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dtCnt <= 16'h0000;
      prevH <= 1'b0;
    end else begin
      prevH <= rawH;
      if (rawH != prevH) begin
        // Transition cycle is itself the first dead cycle
        dtCnt <= (deadEff != 16'h0000) ? deadEff - 16'h0001 : 16'h0000;
      end else if (dtCnt != 16'h0000) begin
        dtCnt <= dtCnt - 16'h0001;
      end
    end
  end

  logic dtBusy;
  assign dtBusy = (dtCnt != 16'h0000) || (rawH != prevH && deadEff != 0);

  // Overlap only in complementary mode and never while disabled
  logic negDt;
  assign negDt = moduleEnable && outputMode == pwmgc_pkg::OM_COMP && dtBusy;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      highOutput <= 1'b0;
      lowOutput <= 1'b0;
    end else begin
      unique case (pwmgc_pkg::pwmgc_dt_e'(ctrl[pwmgc_pkg::B_DTC +: 2]))
        pwmgc_pkg::DT_POS: begin // RQ12
          highOutput <= rawH & ~dtBusy;
          lowOutput <= indep ? rawL : (rawL & ~dtBusy);
        end
        pwmgc_pkg::DT_NEG: begin // RQ12
          highOutput <= rawH | negDt;
          lowOutput <= rawL | negDt;
        end
        pwmgc_pkg::DT_OFF, pwmgc_pkg::DT_RSV: begin // RQ12
          // Reserved code behaves as disabled for safety
          highOutput <= rawH;
          lowOutput <= rawL;
        end
      endcase
    end
  end

endmodule : pwmgc_top

// ---- test_pwm_generator_control_duty.sv ----
// Self-checking testbench of the PWM generator control block
`timescale 1ns/1ns
module test_pwm_generator_control_duty;
  logic ref_clk, nrst, read, write, moduleEnable;
  logic [3:0] address;
  logic [31:0] writedata, readdata;
  logic waitrequest;
  logic [2:0] evPin;
  logic [2:0] evIrq;
  logic [1:0] outs;
  logic [1:0] outputMode;
  logic [13:0] deadTime;
  int errCount = 0;
  int nCompared = 0;
  pwmgc_top dut (.ref_clk(ref_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .faultIn(evPin[0]), .limitIn(evPin[1]),
    .triggerIn(evPin[2]), .primaryTbSync(1'b0), .secondaryTbSync(1'b0),
    .secondaryTbPresent(1'b0), .moduleEnable(moduleEnable),
    .outputMode(outputMode), .deadTime(deadTime), .highOutput(outs[0]),
    .lowOutput(outs[1]), .faultIrq(evIrq[0]), .limitIrq(evIrq[1]),
    .triggerIrq(evIrq[2]));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stopTest();
    if (errCount == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stopTest
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until the stall drops, then lets one edge pass
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [15:0] d, output logic [15:0] q);
    int n = 0;
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata[15:0];
    if (n >= 50) chk(16'h0001, 16'h0000);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rdchk
  // Width in cycles of the pulse after the first one seen on one output
  task automatic width(input int o, output int w);
    int n = 0;
    w = 0;
    // First pulse seen may be cut short by a mode or duty change
    while (outs[o] !== 1'b1 && n < 800) begin @(negedge ref_clk); n++; end
    while (outs[o] === 1'b1 && n < 800) begin @(negedge ref_clk); n++; end
    while (outs[o] !== 1'b1 && n < 800) begin @(negedge ref_clk); n++; end
    while (outs[o] === 1'b1 && w < 400) begin @(negedge ref_clk); w++; end
    @(posedge ref_clk);
  endtask : width
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 5; a++) rdchk(4'(a), 16'h0000);
    rdchk(pwmgc_pkg::ADDR_MPER, pwmgc_pkg::RST_MPER);
    wr(pwmgc_pkg::ADDR_KEY, 16'ha5c3);
    rdchk(pwmgc_pkg::ADDR_KEY, 16'ha5c3);
    wr(pwmgc_pkg::ADDR_CTRL, 16'hffff);
    rdchk(pwmgc_pkg::ADDR_CTRL, pwmgc_pkg::CTRL_WMASK);
    for (int c = 0; c < 4; c++) begin
      wr(pwmgc_pkg::ADDR_CTRL, 16'(c) << pwmgc_pkg::B_DTC);
      rdchk(pwmgc_pkg::ADDR_CTRL, 16'(c) << pwmgc_pkg::B_DTC);
    end
    wr(4'hf, 16'h1234);
    rdchk(4'hf, 16'h0000);
  endtask : t_regs
  // Event with enable set, cleared by enable zero, then ignored
  task automatic t_event(input int i);
    logic [15:0] q;
    int n = 0;
    int seen = 0;
    wr(pwmgc_pkg::ADDR_CTRL, 16'h0001 << (pwmgc_pkg::B_FLTIE - i));
    evPin[i] <= 1'b1;
    do begin @(posedge ref_clk); n++; end while (evIrq[i] !== 1'b1 && n < 20);
    chk(16'(n < 20), 16'h0001);
    repeat (4) @(posedge ref_clk);
    evPin[i] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus(1'b0, pwmgc_pkg::ADDR_CTRL, 16'h0000, q);
    chk(16'(q[pwmgc_pkg::B_FLTST - i]), 16'h0001);
    wr(pwmgc_pkg::ADDR_CTRL, 16'h0000);
    rdchk(pwmgc_pkg::ADDR_CTRL, 16'h0000);
    evPin[i] <= 1'b1;
    repeat (8) begin @(posedge ref_clk); if (evIrq[i] !== 1'b0) seen++; end
    evPin[i] <= 1'b0;
    chk(16'(seen), 16'h0000);
    rdchk(pwmgc_pkg::ADDR_CTRL, 16'h0000);
  endtask : t_event
  task automatic t_duty();
    int w, w2;
    logic [15:0] base;
    base = (16'h0001 << pwmgc_pkg::B_ITB) | 16'h0001 |
      (16'(pwmgc_pkg::DT_OFF) << pwmgc_pkg::B_DTC);
    outputMode <= pwmgc_pkg::OM_INDEP;
    wr(pwmgc_pkg::ADDR_PHASE, 16'h0040);
    wr(pwmgc_pkg::ADDR_SPHASE, 16'h0040);
    wr(pwmgc_pkg::ADDR_PDUTY, 16'h0010);
    wr(pwmgc_pkg::ADDR_SDUTY, 16'h0020);
    // Mode bits change while the generator is disabled, except the dead-time field rewritten later while enabled
    wr(pwmgc_pkg::ADDR_CTRL, base);
    moduleEnable <= 1'b1;
    width(0, w);
    chk(16'(w), 16'h0010);
    width(1, w);
    chk(16'(w), 16'h0020);
    wr(pwmgc_pkg::ADDR_PDUTY, 16'h0002);
    width(0, w);
    chk(16'(w), pwmgc_pkg::MIN_PULSE);
    wr(pwmgc_pkg::ADDR_MDUTY, 16'h0018);
    moduleEnable <= 1'b0;
    wr(pwmgc_pkg::ADDR_CTRL, base | (16'h0001 << pwmgc_pkg::B_MDS));
    moduleEnable <= 1'b1;
    width(0, w);
    chk(16'(w), 16'h0018);
    moduleEnable <= 1'b0;
    wr(pwmgc_pkg::ADDR_CTRL, base);
    moduleEnable <= 1'b1;
    wr(pwmgc_pkg::ADDR_PDUTY, 16'h0010);
    outputMode <= pwmgc_pkg::OM_COMP;
    width(1, w);
    wr(pwmgc_pkg::ADDR_SDUTY, 16'h0008);
    width(1, w2);
    chk(16'(w2), 16'(w));
    deadTime <= 14'h0004;
    wr(pwmgc_pkg::ADDR_CTRL, base & ~(16'h0003 << pwmgc_pkg::B_DTC));
    width(0, w);
    chk(16'(w), 16'h000c);
    moduleEnable <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(16'(outs), 16'h0000);
  endtask : t_duty
  // Limit edge restarts a long local period in external reset mode
  task automatic t_xreset();
    int n = 0;
    wr(pwmgc_pkg::ADDR_PHASE, 16'h0100);
    wr(pwmgc_pkg::ADDR_CTRL, (16'h0001 << pwmgc_pkg::B_ITB) |
      (16'h0001 << pwmgc_pkg::B_XPR) | 16'h0001 |
      (16'(pwmgc_pkg::DT_OFF) << pwmgc_pkg::B_DTC));
    moduleEnable <= 1'b1;
    while (outs[0] !== 1'b1 && n < 600) begin @(negedge ref_clk); n++; end
    while (outs[0] === 1'b1 && n < 600) begin @(negedge ref_clk); n++; end
    @(posedge ref_clk);
    evPin[1] <= 1'b1;
    n = 0;
    while (outs[0] !== 1'b1 && n < 40) begin @(negedge ref_clk); n++; end
    @(posedge ref_clk);
    evPin[1] <= 1'b0;
    chk(16'(n < 8), 16'h0001);
    moduleEnable <= 1'b0;
  endtask : t_xreset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    errCount++;
    stopTest();
  end
  initial begin
    nrst <= 1'b0;
    read <= 1'b0;
    write <= 1'b0;
    address <= 4'h0;
    writedata <= 32'h0000_0000;
    evPin <= 3'b000;
    moduleEnable <= 1'b0;
    outputMode <= pwmgc_pkg::OM_COMP;
    deadTime <= 14'h0000;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_event(0);
    t_event(1);
    t_event(2);
    t_duty();
    t_xreset();
    stopTest();
  end
endmodule : test_pwm_generator_control_duty
